// File: rtl/cbp_pkg.sv
// Purpose: constants for the codec bias and power control register bank
// Assumes: 16-bit registers at word offsets on a plain strobe port
// Notes:   offsets are register indices, not byte addresses
package cbp_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFF_RESET_ID   = 8'h00;
	localparam logic [7:0] OFF_BIAS       = 8'h04;
	localparam logic [7:0] OFF_MIDREF     = 8'h05;
	localparam logic [7:0] OFF_MIC_DETECT = 8'h06;
	localparam logic [7:0] OFF_MIC_LEVEL  = 8'h07;
	localparam logic [7:0] OFF_ADC_OSR    = 8'h0a;
	localparam logic [7:0] OFF_INPUT_AMP  = 8'h0c;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int BIAS_SEL_LSB   = 2;
	localparam int BIAS_GENERATOR_ENABLE_BIT   = 0;
	localparam int MIDREF_PIN_BIT = 6;
	localparam int MIDREF_DIV_LSB = 1;
	localparam int MIDREF_BUF_BIT = 0;
	localparam int MIC_CUR_LSB    = 4;
	localparam int MIC_SHORT_LSB  = 2;
	localparam int MIC_DET_BIT    = 1;
	localparam int MIC_SUP_BIT    = 0;
	localparam int MIC_LEVEL_LSB  = 0;
	localparam int ADC_OSR_BIT    = 0;
	localparam int LEFT_AMP_BIT   = 1;
	localparam int RIGHT_AMP_BIT  = 0;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [1:0] RST_BIAS_SEL   = 2'h2;
	localparam logic       RST_BIAS_GENERATOR_ENABLE   = 1'h0;
	localparam logic       RST_MIDREF_PIN = 1'h0;
	localparam logic [1:0] RST_MIDREF_DIV = 2'h0;
	localparam logic       RST_MIDREF_BUF = 1'h0;
	localparam logic [2:0] RST_MIC_CUR    = 3'h0;
	localparam logic [1:0] RST_MIC_SHORT  = 2'h0;
	localparam logic       RST_MIC_DET    = 1'h0;
	localparam logic       RST_MIC_SUP    = 1'h0;
	localparam logic [2:0] RST_MIC_LEVEL  = 3'h0;
	localparam logic [1:0] RST_MIC_SUPPLY_LEVEL = 2'h0; // decoded level of RST_MIC_LEVEL
	localparam logic       RST_ADC_OSR    = 1'h1;
	localparam logic       RST_LEFT_AMP   = 1'h0;
	localparam logic       RST_RIGHT_AMP  = 1'h0;

	// identity word; value is arbitrary
	localparam logic [15:0] IDENTITY_DEFAULT = 16'h5a31;

	// decoded supply level: four distinct steps, top step shared by 1xx
	localparam logic [1:0] LEVEL_TOP = 2'h3;

endpackage

// File: rtl/cbp_regs.sv
// Purpose: codec bias, midpoint reference, mic supply and input power registers
// Assumes: one clock, software master on a plain strobe port, no waits
// Notes:   read data valid the cycle after the read strobe only; all
//          control outputs come straight from register flip-flops
//
// The address-and-strobe port was left to the implementer.
module cbp_regs #(
	parameter logic [15:0] IDENTITY = cbp_pkg::IDENTITY_DEFAULT
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	output logic      [1:0]  master_bias_select,
	output logic             bias_generator_enable,
	output logic             midref_unused_pin_buffer_enable,
	output logic      [1:0]  midref_divider_select,
	output logic             midref_buffer_enable,
	output logic      [2:0]  mic_current_detect_threshold,
	output logic      [1:0]  mic_short_threshold,
	output logic             mic_detect_enable,
	output logic             mic_supply_enable,
	output logic      [2:0]  mic_supply_level_select,
	output logic      [1:0]  mic_supply_level,
	output logic             adc_high_oversample_select,
	output logic             left_input_amp_enable,
	output logic             right_input_amp_enable
);

	////////////////////////////////////////////////////////////////////////
	// decoded level: codes 1xx all map to the top step
	function automatic logic [1:0] level_of(input logic [2:0] code);
		logic [1:0] lv;
		lv = code[2] ? cbp_pkg::LEVEL_TOP : code[1:0];
		return lv;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// address decode
	wire logic hit_reset  = addr == cbp_pkg::OFF_RESET_ID;
	wire logic hit_bias   = addr == cbp_pkg::OFF_BIAS;
	wire logic hit_midref = addr == cbp_pkg::OFF_MIDREF;
	wire logic hit_det    = addr == cbp_pkg::OFF_MIC_DETECT;
	wire logic hit_level  = addr == cbp_pkg::OFF_MIC_LEVEL;
	wire logic hit_osr    = addr == cbp_pkg::OFF_ADC_OSR;
	wire logic hit_amp    = addr == cbp_pkg::OFF_INPUT_AMP;

	// soft reset is any write at offset zero, data ignored
	wire logic soft_reset = wr && hit_reset;

	////////////////////////////////////////////////////////////////////////
	// register read images; unassigned bits are zero
	wire logic [15:0] img_bias = {12'h000, master_bias_select, 1'b0, bias_generator_enable};
	wire logic [15:0] img_midref = {9'h000, midref_unused_pin_buffer_enable, 3'h0,
		midref_divider_select, midref_buffer_enable};
	wire logic [15:0] img_det = {9'h000, mic_current_detect_threshold, mic_short_threshold,
		mic_detect_enable, mic_supply_enable};
	wire logic [15:0] img_level = {13'h0000, mic_supply_level_select};
	wire logic [15:0] img_osr   = {15'h0000, adc_high_oversample_select};
	wire logic [15:0] img_amp   = {14'h0000, left_input_amp_enable, right_input_amp_enable};

	// read mux; unmapped offsets read zero
	wire logic [15:0] read_mux =
		hit_reset  ? IDENTITY :
		hit_bias   ? img_bias :
		hit_midref ? img_midref :
		hit_det    ? img_det :
		hit_level  ? img_level :
		hit_osr    ? img_osr :
		hit_amp    ? img_amp : 16'h0000;

	wire logic [15:0] next_rdata = rd ? read_mux : 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// read data: stands for one cycle after the strobe, zero otherwise
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rdata <= 16'h0000;
		else
			rdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////
	// per-register write enables; the hit decodes are exclusive, so a write
	// at offset zero only resets and never stores its data word; writes to
	// unmapped offsets match no enable and are dropped
	wire logic wr_bias   = wr && hit_bias;
	wire logic wr_midref = wr && hit_midref;
	wire logic wr_det    = wr && hit_det;
	wire logic wr_level  = wr && hit_level;
	wire logic wr_osr    = wr && hit_osr;
	wire logic wr_amp    = wr && hit_amp;

	////////////////////////////////////////////////////////////////////////
	// next values, bias control; soft reset comes first in every select
	// reserved bias codes are stored as written; the analogue side treats
	// them as undefined, and when to change the select is software's duty
	wire logic [1:0] next_master_bias_select =
		soft_reset ? cbp_pkg::RST_BIAS_SEL :
		wr_bias    ? wdata[cbp_pkg::BIAS_SEL_LSB +: 2] :
		master_bias_select;
	wire logic       next_bias_generator_enable =
		soft_reset ? cbp_pkg::RST_BIAS_GENERATOR_ENABLE :
		wr_bias    ? wdata[cbp_pkg::BIAS_GENERATOR_ENABLE_BIT] :
		bias_generator_enable;

	////////////////////////////////////////////////////////////////////////
	// next values, midpoint reference control; unassigned bits 5:3 and
	// 15:7 of the write word reach no flop
	wire logic       next_midref_unused_pin_buffer_enable =
		soft_reset ? cbp_pkg::RST_MIDREF_PIN :
		wr_midref  ? wdata[cbp_pkg::MIDREF_PIN_BIT] :
		midref_unused_pin_buffer_enable;
	wire logic [1:0] next_midref_divider_select =
		soft_reset ? cbp_pkg::RST_MIDREF_DIV :
		wr_midref  ? wdata[cbp_pkg::MIDREF_DIV_LSB +: 2] :
		midref_divider_select;
	wire logic       next_midref_buffer_enable =
		soft_reset ? cbp_pkg::RST_MIDREF_BUF :
		wr_midref  ? wdata[cbp_pkg::MIDREF_BUF_BIT] :
		midref_buffer_enable;

	////////////////////////////////////////////////////////////////////////
	// next values, mic supply detection; threshold codes pass straight
	// through, the analogue side maps them to current steps
	wire logic [2:0] next_mic_current_detect_threshold =
		soft_reset ? cbp_pkg::RST_MIC_CUR :
		wr_det     ? wdata[cbp_pkg::MIC_CUR_LSB +: 3] :
		mic_current_detect_threshold;
	wire logic [1:0] next_mic_short_threshold =
		soft_reset ? cbp_pkg::RST_MIC_SHORT :
		wr_det     ? wdata[cbp_pkg::MIC_SHORT_LSB +: 2] :
		mic_short_threshold;
	wire logic       next_mic_detect_enable =
		soft_reset ? cbp_pkg::RST_MIC_DET :
		wr_det     ? wdata[cbp_pkg::MIC_DET_BIT] :
		mic_detect_enable;
	wire logic       next_mic_supply_enable =
		soft_reset ? cbp_pkg::RST_MIC_SUP :
		wr_det     ? wdata[cbp_pkg::MIC_SUP_BIT] :
		mic_supply_enable;

	////////////////////////////////////////////////////////////////////////
	// next values, mic level; the decoded level has flops of its own so the
	// output comes from a register instead of through the decoder
	wire logic [2:0] next_mic_supply_level_select =
		soft_reset ? cbp_pkg::RST_MIC_LEVEL :
		wr_level   ? wdata[cbp_pkg::MIC_LEVEL_LSB +: 3] :
		mic_supply_level_select;
	wire logic [1:0] next_mic_supply_level =
		soft_reset ? cbp_pkg::RST_MIC_SUPPLY_LEVEL :
		wr_level   ? level_of(wdata[cbp_pkg::MIC_LEVEL_LSB +: 3]) :
		mic_supply_level;

	////////////////////////////////////////////////////////////////////////
	// next values, oversampling and input amp power; oversampling is the
	// one field of this bank that resets to one
	wire logic       next_adc_high_oversample_select =
		soft_reset ? cbp_pkg::RST_ADC_OSR :
		wr_osr     ? wdata[cbp_pkg::ADC_OSR_BIT] :
		adc_high_oversample_select;
	wire logic       next_left_input_amp_enable =
		soft_reset ? cbp_pkg::RST_LEFT_AMP :
		wr_amp     ? wdata[cbp_pkg::LEFT_AMP_BIT] :
		left_input_amp_enable;
	wire logic       next_right_input_amp_enable =
		soft_reset ? cbp_pkg::RST_RIGHT_AMP :
		wr_amp     ? wdata[cbp_pkg::RIGHT_AMP_BIT] :
		right_input_amp_enable;

	////////////////////////////////////////////////////////////////////////
	// bias control flops; the async reset branch loads constants only,
	// soft reset arrives through the next values
	// bias select, resets to high performance
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			master_bias_select <= cbp_pkg::RST_BIAS_SEL;
		else
			master_bias_select <= next_master_bias_select;
	end

	// bias generator enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			bias_generator_enable <= cbp_pkg::RST_BIAS_GENERATOR_ENABLE;
		else
			bias_generator_enable <= next_bias_generator_enable;
	end

	////////////////////////////////////////////////////////////////////////
	// midpoint reference flops; all three reset to off so the reference
	// comes up disabled until software starts it
	// unused pin buffer enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			midref_unused_pin_buffer_enable <= cbp_pkg::RST_MIDREF_PIN;
		else
			midref_unused_pin_buffer_enable <= next_midref_unused_pin_buffer_enable;
	end

	// divider select
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			midref_divider_select <= cbp_pkg::RST_MIDREF_DIV;
		else
			midref_divider_select <= next_midref_divider_select;
	end

	// reference buffer enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			midref_buffer_enable <= cbp_pkg::RST_MIDREF_BUF;
		else
			midref_buffer_enable <= next_midref_buffer_enable;
	end

	////////////////////////////////////////////////////////////////////////
	// mic supply detection flops; supply and detection come up off so no
	// current flows into an unplugged jack after power-up
	// current detect threshold
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			mic_current_detect_threshold <= cbp_pkg::RST_MIC_CUR;
		else
			mic_current_detect_threshold <= next_mic_current_detect_threshold;
	end

	// short circuit threshold
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			mic_short_threshold <= cbp_pkg::RST_MIC_SHORT;
		else
			mic_short_threshold <= next_mic_short_threshold;
	end

	// detection enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			mic_detect_enable <= cbp_pkg::RST_MIC_DET;
		else
			mic_detect_enable <= next_mic_detect_enable;
	end

	// supply enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			mic_supply_enable <= cbp_pkg::RST_MIC_SUP;
		else
			mic_supply_enable <= next_mic_supply_enable;
	end

	////////////////////////////////////////////////////////////////////////
	// mic level flops; raw code and decoded level always load together so
	// the two outputs never disagree for a cycle
	// raw level code, read back as written
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			mic_supply_level_select <= cbp_pkg::RST_MIC_LEVEL;
		else
			mic_supply_level_select <= next_mic_supply_level_select;
	end

	// decoded level
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			mic_supply_level <= cbp_pkg::RST_MIC_SUPPLY_LEVEL;
		else
			mic_supply_level <= next_mic_supply_level;
	end

	////////////////////////////////////////////////////////////////////////
	// oversampling flop; resets to the high performance ratio
	// one means 128 times, zero the low power 64 times
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			adc_high_oversample_select <= cbp_pkg::RST_ADC_OSR;
		else
			adc_high_oversample_select <= next_adc_high_oversample_select;
	end

	////////////////////////////////////////////////////////////////////////
	// input amp power flops; both sides come up unpowered
	// left input amp enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			left_input_amp_enable <= cbp_pkg::RST_LEFT_AMP;
		else
			left_input_amp_enable <= next_left_input_amp_enable;
	end

	// right input amp enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			right_input_amp_enable <= cbp_pkg::RST_RIGHT_AMP;
		else
			right_input_amp_enable <= next_right_input_amp_enable;
	end

endmodule

// File: testbench/cbp_regs_bench.sv
// Purpose: self-checking bench for the bias and power register bank
// Assumes: strobe master changes inputs by nonblocking assignment after each edge
// Notes:   expected words are written out per row; identity value is arbitrary
module cbp_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} cbp_row_t;
	localparam logic [15:0] IDENT = 16'h3c7e; // arbitrary value
	logic        clock, rst, wr, rd, ben, pin, mbuf, det, sup, osr, lamp, ramp;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata;
	logic [1:0]  bsel, div, sthr, lvl;
	logic [2:0]  thr, lsel;
	int          failures = 0;
	int          n_compared = 0;
	// write, then read back; bias rows are low power entry and exit steps only,
	// with legal select codes; last row is an unmapped offset
	cbp_row_t rows[12] = '{'{8'h04, 16'h0000, 16'h0000}, '{8'h04, 16'hfffb, 16'h0009},
		'{8'h04, 16'h0001, 16'h0001}, '{8'h05, 16'hffff, 16'h0047}, '{8'h05, 16'h0002, 16'h0002},
		'{8'h05, 16'h0004, 16'h0004}, '{8'h06, 16'hffff, 16'h007f}, '{8'h06, 16'h0050, 16'h0050},
		'{8'h07, 16'hfffc, 16'h0004}, '{8'h0a, 16'h0000, 16'h0000}, '{8'h0c, 16'hffff, 16'h0003},
		'{8'h03, 16'hffff, 16'h0000}};
	cbp_row_t defs[6] = '{'{8'h04, 16'h0, 16'h0008}, '{8'h05, 16'h0, 16'h0}, '{8'h06, 16'h0, 16'h0},
		'{8'h07, 16'h0, 16'h0}, '{8'h0a, 16'h0, 16'h0001}, '{8'h0c, 16'h0, 16'h0}};
	cbp_regs #(.IDENTITY(IDENT)) u_cbp_regs (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .master_bias_select(bsel), .bias_generator_enable(ben), .midref_unused_pin_buffer_enable(pin),
		.midref_divider_select(div), .midref_buffer_enable(mbuf), .mic_current_detect_threshold(thr),
		.mic_short_threshold(sthr), .mic_detect_enable(det), .mic_supply_enable(sup), .mic_supply_level_select(lsel),
		.mic_supply_level(lvl), .adc_high_oversample_select(osr), .left_input_amp_enable(lamp),
		.right_input_amp_enable(ramp));
	////////////////////////////////////////////////////////////////////////
	// one bus slot: strobes last one cycle because the next slot clears them
	task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask
	// read data exists only in the cycle after the read slot
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		acc(1'b0, 1'b1, a, 16'h0000);
		acc(1'b0, 1'b0, a, 16'h0000);
		#1 chk("rdata", e, rdata);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// watchdog; the sequence needs well under 200 cycles
	initial begin
		repeat (2000) @(posedge clock);
		failures++;
		report_and_stop();
	end
	initial begin
		{rst, wr, rd, addr, wdata} = {1'b1, 1'b0, 1'b0, 8'h00, 16'h0000};
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		foreach (defs[i]) rd_chk(defs[i].a, defs[i].e);
		foreach (rows[i]) begin
			acc(1'b1, 1'b0, rows[i].a, rows[i].d);
			rd_chk(rows[i].a, rows[i].e);
		end
		chk("level", 16'h0003, {14'h0000, lvl});
		acc(1'b1, 1'b0, 8'h07, 16'h0002);
		acc(1'b0, 1'b0, 8'h07, 16'h0000);
		#1 chk("level", 16'h0002, {14'h0000, lvl});
		rd_chk(8'h00, IDENT);
		acc(1'b0, 1'b0, 8'h00, 16'h0000);
		#1 chk("rdata idle", 16'h0000, rdata);
		acc(1'b1, 1'b0, 8'h00, 16'h1234);
		foreach (defs[i]) rd_chk(defs[i].a, defs[i].e);
		rd_chk(8'h00, IDENT);
		// hardware reset in mid-run, raised just after an edge with no strobe up
		acc(1'b1, 1'b0, 8'h0c, 16'hffff);
		acc(1'b1, 1'b0, 8'h0a, 16'h0000);
		acc(1'b0, 1'b0, 8'h0a, 16'h0000);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		foreach (defs[i]) rd_chk(defs[i].a, defs[i].e);
		report_and_stop();
	end
endmodule

// File: testbench/cbp_regs_checker.sv
// Purpose: port-level assertions for the bias and power register bank
// Assumes: one clock, asynchronous active-high reset, strobes never together
// Notes:   write effects show one cycle after the strobe edge
module cbp_regs_checker #(
	parameter logic [15:0] IDENTITY = cbp_pkg::IDENTITY_DEFAULT
) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [7:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic [1:0]  master_bias_select,
	input wire logic        bias_generator_enable,
	input wire logic        midref_unused_pin_buffer_enable,
	input wire logic [1:0]  midref_divider_select,
	input wire logic        midref_buffer_enable,
	input wire logic [2:0]  mic_current_detect_threshold,
	input wire logic [1:0]  mic_short_threshold,
	input wire logic        mic_detect_enable,
	input wire logic        mic_supply_enable,
	input wire logic [2:0]  mic_supply_level_select,
	input wire logic [1:0]  mic_supply_level,
	input wire logic        adc_high_oversample_select,
	input wire logic        left_input_amp_enable,
	input wire logic        right_input_amp_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	// soft reset: request, then every field back at its default
	sequence soft_req;
		wr && addr == 8'h00;
	endsequence
	sequence all_defaults;
		{master_bias_select, bias_generator_enable, midref_unused_pin_buffer_enable, midref_divider_select,
		midref_buffer_enable} == 7'h40 && {mic_current_detect_threshold, mic_short_threshold, mic_detect_enable,
		mic_supply_enable, mic_supply_level_select, mic_supply_level, adc_high_oversample_select,
		left_input_amp_enable, right_input_amp_enable} == 15'h0004;
	endsequence
	////////////////////////////////////////////////////////////////////////
	soft_reset_a: assert property (soft_req |=> all_defaults)
		else $error("soft reset left a field off its default");
	identity_read_a: assert property (rd && addr == 8'h00 |=> rdata == IDENTITY)
		else $error("identity read wrong");
	bias_write_a: assert property (wr && addr == 8'h04 |=> master_bias_select == $past(wdata[3:2])
		&& bias_generator_enable == $past(wdata[0])) else $error("bias control write wrong");
	midref_write_a: assert property (wr && addr == 8'h05 |=> {midref_unused_pin_buffer_enable,
		midref_divider_select, midref_buffer_enable} == {$past(wdata[6]), $past(wdata[2:0])})
		else $error("midpoint reference write wrong");
	mic_read_a: assert property (rd && addr == 8'h06 |=>
		rdata == {9'h000, mic_current_detect_threshold, mic_short_threshold, mic_detect_enable, mic_supply_enable})
		else $error("mic detect readback wrong");
	mic_write_a: assert property (wr && addr == 8'h06 |=>
		{mic_current_detect_threshold, mic_short_threshold, mic_detect_enable, mic_supply_enable} == $past(wdata[6:0]))
		else $error("mic detect write wrong");
	level_write_a: assert property (wr && addr == 8'h07 |=> mic_supply_level_select == $past(wdata[2:0])
		&& mic_supply_level == ($past(wdata[2]) ? 2'h3 : $past(wdata[1:0])))
		else $error("mic supply level wrong");
	osr_write_a: assert property (wr && addr == 8'h0a |=> adc_high_oversample_select == $past(wdata[0]))
		else $error("oversampling write wrong");
	amp_write_a: assert property (wr && addr == 8'h0c |=>
		{left_input_amp_enable, right_input_amp_enable} == $past(wdata[1:0])) else $error("amp enable write wrong");
	idle_read_a: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data outside read slot");
	bias_hold_a: assert property (!wr |=>
		$stable(master_bias_select) && $stable(adc_high_oversample_select))
		else $error("field changed without a write");
endmodule
////////////////////////////////////////////////////////////////////////////
bind cbp_regs cbp_regs_checker #(.IDENTITY(IDENTITY)) u_cbp_regs_checker (.clock(clock), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .master_bias_select(master_bias_select),
	.bias_generator_enable(bias_generator_enable), .midref_unused_pin_buffer_enable(midref_unused_pin_buffer_enable),
	.midref_divider_select(midref_divider_select), .midref_buffer_enable(midref_buffer_enable),
	.mic_current_detect_threshold(mic_current_detect_threshold), .mic_short_threshold(mic_short_threshold),
	.mic_detect_enable(mic_detect_enable), .mic_supply_enable(mic_supply_enable),
	.mic_supply_level_select(mic_supply_level_select), .mic_supply_level(mic_supply_level),
	.adc_high_oversample_select(adc_high_oversample_select), .left_input_amp_enable(left_input_amp_enable),
	.right_input_amp_enable(right_input_amp_enable));
